//--- core/adc_audio_pkg.sv
/*
  Shared constants for the converter control and sound-driven light block:
  register offsets, field positions, reset values, timing counts, state type.
  Assumes a single 50 MHz system clock.
*/
package adc_audio_pkg;
  // =========================================
  // clocking and conversion timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CONV_HZ = 1_000_000;
  localparam int TICK_DIV = CLK_HZ / CONV_HZ;
  localparam int CONV_TIME_US = 27;
  localparam int CONV_TICKS = CONV_TIME_US * CONV_HZ / 1_000_000;
  localparam int SETTLE_TICKS = 16;
  localparam int CONV_CYCLES = CONV_TICKS * TICK_DIV;
  localparam int RESULT_BITS = 10;
  localparam logic [9:0] MID_CODE = 10'h200;

  // =========================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h26;
  localparam logic [7:0] ADDR_RES_HI = 8'h27;
  localparam logic [7:0] ADDR_RES_LO = 8'h28;
  localparam logic [7:0] ADDR_SOUND_CTRL = 8'h46;
  localparam logic [7:0] ADDR_SOUND_GAIN = 8'h47;
  localparam logic [7:0] ADDR_SOUND_OUT = 8'h48;
  localparam logic [7:0] ADDR_ROUTE = 8'h53;
  localparam logic [7:0] ADDR_SOUND_CTRL2 = 8'h55;

  // =========================================
  // fields and reset values
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 7;
  localparam logic [5:0] SELECT_RESET = 6'h03;
  localparam int BUF_ON_BIT = 0;
  localparam int COLOUR_LSB = 2;
  localparam int DOWN_LSB = 6;
  localparam int AGC_LSB = 3;
  localparam int PRECHARGE_LSB = 6;
  localparam int HV_EN_BIT = 4;
  localparam int RGB_EN_BIT = 5;
  localparam int G4_EN_BIT = 6;
  localparam int UP_LSB = 1;
  localparam int SOURCE_LSB = 4;

  // =========================================
  // sound processing timing
  localparam int RAMP_STEPS = 256;
  localparam int UP_MS [8] = '{0, 50, 100, 150, 200, 250, 400, 800};
  localparam int DOWN_MS [4] = '{0, 200, 400, 800};
  localparam int DECAY_SLOW_US = 1000;
  localparam int DECAY_FAST_US = 100;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_SETTLE = 2'b01,
    SAR_TRIAL = 2'b10,
    SAR_FINISH = 2'b11
  } sar_state_type;
endpackage : adc_audio_pkg

//--- core/sar_converter.sv
/*
  Successive-approximation sequencer: sample phase, ten bit trials, result.
  Assumes a 1 MHz tick enable on ref_clk and an analog comparator pin.
*/
`timescale 1ns/1ns
module sar_converter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  // control
  input wire logic start,
  output logic busy,
  output logic done,
  output logic [9:0] result,
  // analog side
  input wire logic cmpAbove,
  output logic [9:0] dacCode,
  output logic sampleHold
);
  adc_audio_pkg::sar_state_type state;
  logic [4:0] step;
  logic [3:0] bitIdx;
  logic cmpMeta;
  logic cmpSync;
  logic [11:0] busyCycles;

  // =========================================
  // comparator synchroniser
  always_ff @(posedge ref_clk) begin
    cmpMeta <= cmpAbove;
    cmpSync <= cmpMeta;
  end

  // =========================================
  // sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= adc_audio_pkg::SAR_IDLE;
      step <= 5'h00;
      bitIdx <= 4'h0;
      dacCode <= 10'h000;
      result <= 10'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        adc_audio_pkg::SAR_IDLE: begin
          if (start) begin
            state <= adc_audio_pkg::SAR_SETTLE;
            step <= 5'h00;
          end
        end
        adc_audio_pkg::SAR_SETTLE: begin
          if (tick) begin
            step <= step + 5'h01;
            if (step == 5'(adc_audio_pkg::SETTLE_TICKS - 1)) begin
              state <= adc_audio_pkg::SAR_TRIAL;
              dacCode <= adc_audio_pkg::MID_CODE;
              bitIdx <= 4'(adc_audio_pkg::RESULT_BITS - 1);
            end
          end
        end
        adc_audio_pkg::SAR_TRIAL: begin
          if (tick) begin
            // keep the trial bit only while input stays above the guess
            if (!cmpSync) dacCode[bitIdx] <= 1'b0;
            if (bitIdx == 4'h0) begin
              state <= adc_audio_pkg::SAR_FINISH;
            end else begin
              dacCode[bitIdx - 4'h1] <= 1'b1;
              bitIdx <= bitIdx - 4'h1;
            end
          end
        end
        adc_audio_pkg::SAR_FINISH: begin
          if (tick) begin
            result <= dacCode;
            done <= 1'b1;
            state <= adc_audio_pkg::SAR_IDLE;
          end
        end
        default: state <= adc_audio_pkg::SAR_IDLE;
      endcase
    end
  end

  assign busy = (state != adc_audio_pkg::SAR_IDLE);
  assign sampleHold = (state == adc_audio_pkg::SAR_SETTLE);

  always_ff @(posedge ref_clk) begin
    if (rst || !busy) busyCycles <= 12'h000;
    else busyCycles <= busyCycles + 12'h001;
  end

  chk_conv_length: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(busy) |-> ($past(busyCycles) >= 12'(adc_audio_pkg::CONV_CYCLES - adc_audio_pkg::TICK_DIV))
      && ($past(busyCycles) < 12'(adc_audio_pkg::CONV_CYCLES)))
    else $error("conversion length outside 27 converter clocks");
endmodule : sar_converter

//--- core/adc_audio_ctrl.sv
/*
  Converter control registers and sound-driven light processing.
  Assumes the serial interface decoder presents one-cycle register strobes
  on ref_clk and that the analog comparator is asynchronous to it.
*/
`timescale 1ns/1ns
module adc_audio_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // converter analog side
  input wire logic cmpAbove,
  output logic [9:0] dacCode,
  output logic sampleHold,
  output logic [5:0] inputSelect,
  output logic prescaleEnable,
  // sound input buffer
  output logic bufferEnable,
  output logic [2:0] bufferGain,
  output logic [1:0] prechargeMode,
  output logic [1:0] bufferSource,
  // sound light outputs
  output logic soundActive,
  output logic [7:0] chanRed,
  output logic [7:0] chanGreen,
  output logic [7:0] chanBlue,
  output logic [2:0] amplitudeScale,
  output logic [7:0] sinkGroup3ChannelRoute,
  output logic hvSinksSoundEnable,
  output logic rgbSinksSoundEnable,
  output logic group4SinksSoundEnable
);
  logic [5:0] tickCnt;
  logic tick;
  logic hostStart;
  logic convStart;
  logic convBusy;
  logic convDone;
  logic [9:0] convResult;
  logic [9:0] resultCode;
  logic [2:0] colour;
  logic [1:0] downSel;
  logic [2:0] agcSel;
  logic [2:0] upSel;
  logic [9:0] amp;
  logic [9:0] env;
  logic [15:0] decayCnt;
  logic [3:0] level;
  logic [15:0] prod;
  logic [7:0] target;
  logic [7:0] bright;
  logic [15:0] rampCnt;
  logic [2:0] rgb;

  // =========================================
  // helpers
  function automatic logic [7:0] sat8(input logic [15:0] v);
    sat8 = (v > 16'h00ff) ? 8'hff : v[7:0];
  endfunction : sat8

  function automatic logic [15:0] stepPeriod(input int ms);
    stepPeriod = 16'((ms * 1000) / adc_audio_pkg::RAMP_STEPS);
  endfunction : stepPeriod

  // gain in eighths for an envelope level
  function automatic logic [5:0] agcGain(input logic [2:0] sel, input logic [3:0] lvl);
    agcGain = 6'd8;
    if (sel == 3'b001) begin
      agcGain = (lvl < 4'd2) ? 6'd0 : 6'd8;
    end else if (sel != 3'b000) begin
      if (lvl == 4'd0) agcGain = 6'd0;
      else if (sel[2:1] == 2'b01) agcGain = (lvl < 4'd12) ? 6'd16 : 6'd8;
      else if (sel[2:1] == 2'b10) agcGain = (lvl < 4'd9) ? 6'd24 : 6'(6'd32 - {2'b00, lvl} - {2'b00, lvl});
      else agcGain = (lvl < 4'd12) ? 6'd32 : 6'd8;
    end
  endfunction : agcGain

  // high-voltage capable inputs pass the divider
  function automatic logic dividedInput(input logic [5:0] sel);
    dividedInput = ((sel >= 6'h05) && (sel <= 6'h07)) || ((sel >= 6'h0a) && (sel <= 6'h10))
      || (sel == 6'h14) || (sel == 6'h15);
  endfunction : dividedInput

  // =========================================
  // converter clock enable
  always_ff @(posedge ref_clk) begin
    if (rst || tickCnt == 6'(adc_audio_pkg::TICK_DIV - 1)) tickCnt <= 6'h00;
    else tickCnt <= tickCnt + 6'h01;
  end
  assign tick = (tickCnt == 6'h00);

  // =========================================
  // register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inputSelect <= adc_audio_pkg::SELECT_RESET;
      bufferEnable <= 1'b0;
      colour <= 3'b000;
      downSel <= 2'b00;
      bufferGain <= 3'b000;
      agcSel <= 3'b000;
      prechargeMode <= 2'b00;
      amplitudeScale <= 3'b000;
      hvSinksSoundEnable <= 1'b0;
      rgbSinksSoundEnable <= 1'b0;
      group4SinksSoundEnable <= 1'b0;
      sinkGroup3ChannelRoute <= 8'h00;
      upSel <= 3'b000;
      bufferSource <= 2'b00;
    end else if (regWrite) begin
      if (regAddr == adc_audio_pkg::ADDR_CTRL) begin
        inputSelect <= regWrData[5:0];
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_CTRL) begin
        bufferEnable <= regWrData[adc_audio_pkg::BUF_ON_BIT];
        colour <= regWrData[adc_audio_pkg::COLOUR_LSB +: 3];
        downSel <= regWrData[adc_audio_pkg::DOWN_LSB +: 2];
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_GAIN) begin
        bufferGain <= regWrData[2:0];
        agcSel <= regWrData[adc_audio_pkg::AGC_LSB +: 3];
        prechargeMode <= regWrData[adc_audio_pkg::PRECHARGE_LSB +: 2];
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_OUT) begin
        amplitudeScale <= regWrData[2:0];
        hvSinksSoundEnable <= regWrData[adc_audio_pkg::HV_EN_BIT];
        rgbSinksSoundEnable <= regWrData[adc_audio_pkg::RGB_EN_BIT];
        group4SinksSoundEnable <= regWrData[adc_audio_pkg::G4_EN_BIT];
      end else if (regAddr == adc_audio_pkg::ADDR_ROUTE) begin
        sinkGroup3ChannelRoute <= regWrData;
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_CTRL2) begin
        upSel <= regWrData[adc_audio_pkg::UP_LSB +: 3];
        bufferSource <= regWrData[adc_audio_pkg::SOURCE_LSB +: 2];
      end
    end
  end

  assign prescaleEnable = dividedInput(inputSelect);

  // =========================================
  // register reads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      if (regAddr == adc_audio_pkg::ADDR_CTRL) begin
        regRdData <= {2'b00, inputSelect};
      end else if (regAddr == adc_audio_pkg::ADDR_RES_HI) begin
        // done still pending: result lands in resultCode one cycle later
        regRdData <= {convBusy | convDone, resultCode[9:3]};
      end else if (regAddr == adc_audio_pkg::ADDR_RES_LO) begin
        regRdData <= {5'h00, resultCode[2:0]};
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_CTRL) begin
        regRdData <= {downSel, 1'b0, colour, 1'b0, bufferEnable};
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_GAIN) begin
        regRdData <= {prechargeMode, agcSel, bufferGain};
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_OUT) begin
        regRdData <= {1'b0, group4SinksSoundEnable, rgbSinksSoundEnable, hvSinksSoundEnable, 1'b0, amplitudeScale};
      end else if (regAddr == adc_audio_pkg::ADDR_ROUTE) begin
        regRdData <= sinkGroup3ChannelRoute;
      end else if (regAddr == adc_audio_pkg::ADDR_SOUND_CTRL2) begin
        regRdData <= {2'b00, bufferSource, upSel, 1'b0};
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // =========================================
  // conversion launch
  // start is delayed a cycle so a combined write converts the new select
  always_ff @(posedge ref_clk) begin
    if (rst) hostStart <= 1'b0;
    else hostStart <= regWrite && (regAddr == adc_audio_pkg::ADDR_CTRL)
      && regWrData[adc_audio_pkg::START_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) soundActive <= 1'b0;
    else soundActive <= (|sinkGroup3ChannelRoute) || hvSinksSoundEnable
      || rgbSinksSoundEnable || group4SinksSoundEnable;
  end

  // sound mode owns the converter; host starts are dropped meanwhile
  assign convStart = soundActive ? !convBusy : hostStart;

  sar_converter u_sar (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick),
    .start(convStart),
    .busy(convBusy),
    .done(convDone),
    .result(convResult),
    .cmpAbove(cmpAbove),
    .dacCode(dacCode),
    .sampleHold(sampleHold)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) resultCode <= 10'h000;
    else if (convDone) resultCode <= convResult;
  end

  // =========================================
  // envelope tracker
  assign amp = (convResult >= adc_audio_pkg::MID_CODE) ? (convResult - adc_audio_pkg::MID_CODE)
    : (adc_audio_pkg::MID_CODE - convResult);

  always_ff @(posedge ref_clk) begin
    if (rst || !soundActive) begin
      env <= 10'h000;
      decayCnt <= 16'h0000;
    end else if (convDone && amp > env) begin
      env <= amp;
      decayCnt <= 16'h0000;
    end else if (tick) begin
      // odd compression codes decay fast
      if (decayCnt >= 16'(agcSel[0] ? adc_audio_pkg::DECAY_FAST_US : adc_audio_pkg::DECAY_SLOW_US)) begin
        decayCnt <= 16'h0000;
        if (env != 10'h000) env <= env - 10'h001;
      end else begin
        decayCnt <= decayCnt + 16'h0001;
      end
    end
  end

  assign level = env[9] ? 4'hf : env[8:5];

  // =========================================
  // gain compression
  // widen both operands so the product is not cut to the amplitude width
  assign prod = {6'h00, amp} * {10'h000, agcGain(agcSel, level)};

  always_ff @(posedge ref_clk) begin
    if (rst || !soundActive) target <= 8'h00;
    else if (convDone) target <= sat8(prod >> 4);
  end

  // =========================================
  // ramp timing
  // one step per period so a full-scale swing takes the selected time
  always_ff @(posedge ref_clk) begin
    if (rst || !soundActive) begin
      bright <= 8'h00;
      rampCnt <= 16'h0000;
    end else if (target > bright) begin
      if (upSel == 3'b000) begin
        bright <= target;
      end else if (tick) begin
        if (rampCnt >= stepPeriod(adc_audio_pkg::UP_MS[upSel])) begin
          rampCnt <= 16'h0000;
          bright <= bright + 8'h01;
        end else begin
          rampCnt <= rampCnt + 16'h0001;
        end
      end
    end else if (target < bright) begin
      if (downSel == 2'b00) begin
        bright <= target;
      end else if (tick) begin
        if (rampCnt >= stepPeriod(adc_audio_pkg::DOWN_MS[downSel])) begin
          rampCnt <= 16'h0000;
          bright <= bright - 8'h01;
        end else begin
          rampCnt <= rampCnt + 16'h0001;
        end
      end
    end else begin
      rampCnt <= 16'h0000;
    end
  end

  // =========================================
  // colour mapping
  always_comb begin
    rgb = colour;
    if (colour == 3'b000) begin
      case (bright[7:5])
        3'd0: rgb = 3'b000;
        3'd1: rgb = 3'b001;
        3'd2: rgb = 3'b010;
        3'd3: rgb = 3'b011;
        3'd4: rgb = 3'b110;
        3'd5: rgb = 3'b100;
        default: rgb = 3'b111;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chanRed <= 8'h00;
      chanGreen <= 8'h00;
      chanBlue <= 8'h00;
    end else begin
      chanRed <= rgb[2] ? bright : 8'h00;
      chanGreen <= rgb[1] ? bright : 8'h00;
      chanBlue <= rgb[0] ? bright : 8'h00;
    end
  end

  // =========================================
  // checks
  chk_start_runs: assert property (@(posedge ref_clk) disable iff (rst)
    (regWrite && regAddr == adc_audio_pkg::ADDR_CTRL && regWrData[7] && !soundActive && !convBusy)
      |-> ##2 convBusy)
    else $error("start write did not launch a conversion");

  chk_busy_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (regRead && regAddr == adc_audio_pkg::ADDR_RES_HI) |=> regRdData[7] == $past(convBusy || convDone))
    else $error("running flag does not follow conversion");

  chk_low_result: assert property (@(posedge ref_clk) disable iff (rst)
    (regRead && regAddr == adc_audio_pkg::ADDR_RES_LO) |=> regRdData == {5'h00, $past(resultCode[2:0])})
    else $error("low result register mismatch");

  chk_select_start: assert property (@(posedge ref_clk) disable iff (rst)
    (regWrite && regAddr == adc_audio_pkg::ADDR_CTRL && regWrData[7] && !soundActive && !convBusy)
      |-> ##2 (inputSelect == $past(regWrData[5:0], 2)))
    else $error("conversion did not use the new select");

  chk_result_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !convDone |=> $stable(resultCode))
    else $error("result changed without a completed conversion");

  chk_sound_enable: assert property (@(posedge ref_clk) disable iff (rst)
    (|sinkGroup3ChannelRoute || hvSinksSoundEnable || rgbSinksSoundEnable || group4SinksSoundEnable)
      |=> soundActive)
    else $error("sound function not active");

  chk_sound_continuous: assert property (@(posedge ref_clk) disable iff (rst)
    (soundActive && convDone) |-> ##[1:3] (convBusy || !soundActive))
    else $error("sound mode stopped converting");

  chk_comp_off: assert property (@(posedge ref_clk) disable iff (rst)
    (agcSel == 3'b000 && soundActive && convDone) |=> target == sat8({7'h00, $past(amp[9:1])}))
    else $error("compression not bypassed");

  chk_single_colour: assert property (@(posedge ref_clk) disable iff (rst)
    (colour != 3'b000 && !colour[2]) [*2] |-> chanRed == 8'h00)
    else $error("red channel lit in single colour without red");

  chk_divider_sel: assert property (@(posedge ref_clk) disable iff (rst)
    (inputSelect == 6'h14) |-> prescaleEnable)
    else $error("supply input not divided");
endmodule : adc_audio_ctrl

//--- tb/analog_front_model.sv
/*
  Comparator model for the converter's analog side: each input select
  carries a fixed level, compared against the trial code.
  Assumes the design synchronises cmpAbove itself.
*/
`timescale 1ns/1ns
module analog_front_model (
  // converter analog side
  input wire logic [5:0] inputSelect,
  input wire logic [9:0] dacCode,
  output logic cmpAbove
);
  // =========================================
  // input levels
  logic [9:0] level;
  // select zero sits at 0 V, so it must give code zero
  assign level = 10'({4'h0, inputSelect} * 10'd43);
  // level held steady through a conversion, like a settled sample
  assign cmpAbove = level >= dacCode;
endmodule : analog_front_model

//--- tb/testbench.sv
/*
  Self-checking bench: register tasks, host conversions, sound enables
  and colour selection.
  Assumes analog_front_model on the comparator side.
*/
`timescale 1ns/1ns
module testbench;
  // =========================================
  // signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData, chanRed, chanGreen, chanBlue, sinkGroup3ChannelRoute;
  logic cmpAbove, sampleHold, prescaleEnable, bufferEnable, soundActive;
  logic hvSinksSoundEnable, rgbSinksSoundEnable, group4SinksSoundEnable;
  logic [9:0] dacCode;
  logic [5:0] inputSelect;
  logic [2:0] bufferGain, amplitudeScale;
  logic [1:0] prechargeMode, bufferSource;
  logic [7:0] d;
  logic [23:0] e24;
  logic [15:0] en [5] = '{16'h4810, 16'h4820, 16'h4840, 16'h5301, 16'h5380};
  logic [5:0] sel [6] = '{6'h00, 6'h05, 6'h0b, 6'h14, 6'h16, 6'h17};
  int bad_count = 0;
  int compares = 0;
  int n;

  adc_audio_ctrl dut (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .cmpAbove(cmpAbove),
    .dacCode(dacCode), .sampleHold(sampleHold), .inputSelect(inputSelect),
    .prescaleEnable(prescaleEnable), .bufferEnable(bufferEnable), .bufferGain(bufferGain),
    .prechargeMode(prechargeMode), .bufferSource(bufferSource), .soundActive(soundActive),
    .chanRed(chanRed), .chanGreen(chanGreen), .chanBlue(chanBlue), .amplitudeScale(amplitudeScale),
    .sinkGroup3ChannelRoute(sinkGroup3ChannelRoute), .hvSinksSoundEnable(hvSinksSoundEnable),
    .rgbSinksSoundEnable(rgbSinksSoundEnable), .group4SinksSoundEnable(group4SinksSoundEnable));

  analog_front_model front (.inputSelect(inputSelect), .dacCode(dacCode), .cmpAbove(cmpAbove));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // =========================================
  // tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic timed_out;
    bad_count++;
    $display("wait limit reached at t=%0t", $time);
    give_verdict();
  endtask : timed_out

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    // let the register update settle before callers look at ports
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask : rd

  // one host conversion, timed by polling the running flag
  task automatic conv(input logic [5:0] s);
    logic [7:0] v;
    logic [9:0] e;
    time t0;
    int k;
    e = 10'({4'h0, s} * 10'd43);
    wr(8'h26, {2'b10, s});
    t0 = $time;
    rd(8'h27, v);
    chk(v & 8'h80, 8'h80);
    chk({7'h00, sampleHold}, 8'h01);
    k = 0;
    while (v[7] !== 1'b0 && k < 1000) begin
      rd(8'h27, v);
      k++;
    end
    if (k >= 1000) timed_out();
    k = int'(($time - t0) / 20);
    chk(8'(k > adc_audio_pkg::CONV_CYCLES - 55 && k < adc_audio_pkg::CONV_CYCLES + 8), 8'h01);
    chk(v & 8'h7f, {1'b0, e[9:3]});
    chk(8'(dacCode >> 2), e[9:2]);
    rd(8'h28, v);
    chk(v & 8'h07, {5'h00, e[2:0]});
  endtask : conv

  initial begin
    repeat (90000) @(posedge ref_clk);
    timed_out();
  end

  // =========================================
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h26, d);
    chk(d, 8'h03);
    rd(8'h30, d);
    chk(d, 8'h00);
    for (int g = 0; g < 8; g++) begin
      wr(8'h47, 8'(g));
      chk({5'h00, bufferGain}, 8'(g));
    end
    rd(8'h47, d);
    chk(d, 8'h07);
    wr(8'h47, 8'h00);
    wr(8'h46, 8'h01);
    chk({7'h00, bufferEnable}, 8'h01);
    rd(8'h46, d);
    chk(d, 8'h01);
    wr(8'h55, 8'h3e);
    rd(8'h55, d);
    chk(d, 8'h3e);
    chk({6'h00, bufferSource}, 8'h03);
    wr(8'h55, 8'h00);
    wr(8'h47, 8'hc0);
    chk({6'h00, prechargeMode}, 8'h03);
    wr(8'h47, 8'h00);
    // boost feedback pin conversion as used by the string test
    conv(6'h16);
    foreach (sel[i]) begin
      conv(sel[i]);
      chk({2'b00, inputSelect}, {2'b00, sel[i]});
      chk({7'h00, prescaleEnable}, 8'((sel[i] >= 5 && sel[i] <= 7) || (sel[i] >= 10 && sel[i] <= 16)
        || sel[i] == 20 || sel[i] == 21));
    end
    // select change alone must not disturb the stored result
    wr(8'h26, 8'h05);
    rd(8'h27, d);
    chk(d, 8'h7b);
    rd(8'h28, d);
    chk(d & 8'h07, 8'h05);
    rd(8'h26, d);
    chk(d, 8'h05);
    // direct sound input: buffer off with select 00h
    wr(8'h46, 8'h00);
    wr(8'h26, 8'h00);
    foreach (en[i]) begin
      wr(en[i][15:8], en[i][7:0]);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, soundActive}, 8'h01);
      rd(en[i][15:8], d);
      chk(d, en[i][7:0]);
      wr(en[i][15:8], 8'h00);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, soundActive}, 8'h00);
    end
    wr(8'h48, 8'h20);
    chk({7'h00, rgbSinksSoundEnable}, 8'h01);
    // running flag must stay up across two back-to-back conversions
    for (int r = 0; r < 8; r++) begin
      rd(8'h27, d);
      chk(d & 8'h80, 8'h80);
      repeat (337) @(posedge ref_clk);
    end
    for (int c = 0; c < 8; c++) begin
      e24 = (c == 0) ? 24'hffffff : {{8{c[2]}}, {8{c[1]}}, {8{c[0]}}};
      wr(8'h46, 8'(c << 2));
      n = 0;
      while ({chanRed, chanGreen, chanBlue} !== e24 && n < 6000) begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 6000) timed_out();
      chk(chanRed, e24[23:16]);
      chk(chanGreen, e24[15:8]);
      chk(chanBlue, e24[7:0]);
    end
    give_verdict();
  end
endmodule : testbench
